// >>> core/report_byte_mailbox.sv
// Report byte mailbox between the USB host and an external microcontroller.
// Assumes the serial slave and HID endpoint logic deliver one-cycle strobes.
`timescale 1ns/1ps
module report_byte_mailbox
   import mailbox_pkg::*;
#(
   parameter int GPIO_W = 8
) (
   input  wire logic              clk,
   input  wire logic              srst,
   // Micro side serial slave register strobes
   input  wire logic              mcu_wr,
   input  wire logic              mcu_rd,
   input  wire logic [2:0]        mcu_addr,
   input  wire logic [7:0]        mcu_wdata,
   output logic      [7:0]        mcu_rdata,
   // Host side output report write and input report image
   input  wire logic              host_wr,
   input  wire logic [2:0]        host_addr,
   input  wire logic [7:0]        host_wdata,
   input  wire logic              host_report_done,
   output logic      [31:0]       host_in_report,
   // Buttons and NVM engine
   input  wire logic              rec_mute_btn,
   input  wire logic              play_mute_btn,
   input  wire logic              vol_down_btn,
   input  wire logic              vol_up_btn,
   input  wire logic              nvm_done,
   input  wire logic [7:0]        nvm_rd_low,
   input  wire logic [7:0]        nvm_rd_high,
   output logic                   nvm_start,
   output logic [7:0]             nvm_data_low,
   output logic [7:0]             nvm_data_high,
   output logic [7:0]             nvm_ctrl,
   output logic [1:0]             mcu_clk_sel,
   // Pins and side functions
   input  wire logic [7:0]        spdif_config,
   output logic [GPIO_W-1:0]      general_output_pins,
   output logic [GPIO_W-1:0]      general_output_pins_oe,
   output logic                   buzzer_on,
   output logic [7:0]             spdif_category,
   output logic                   spdif_category_valid,
   output logic                   micro_attention_irq
);
   logic [7:0] up0, up1, up2, up3;
   logic [7:0] dn0, dn1, dn2, dn3;
   logic [7:0] mcu_ctrl;
   logic       rec_prev, play_prev, rec_click, play_click;
   logic       nvm_pending;

   // ************************************************************
   // Decode
   // ************************************************************
   wire logic [1:0] dn_mode   = dn0[MODE_HI:MODE_LO];
   wire logic       dn_mirror = dn0[MODE_HI];
   wire logic       up_mirror = up0[MODE_HI];
   // Micro upstream byte write wins the cycle, so host strobe is dropped then
   wire logic mcu_wr_up = mcu_wr && !mcu_addr[2];
   wire logic host_ok   = host_wr && host_addr[2] && !mcu_wr_up;
   wire logic ctrl_wr_mcu  = mcu_wr && mcu_addr == OFF_UP3 && up_mirror;
   wire logic ctrl_wr_host = host_ok && host_addr == OFF_DN3 && dn_mirror;
   wire logic mcu_ctrl_wr_mcu  = mcu_wr && mcu_addr == OFF_UP0 && up_mirror;
   wire logic mcu_ctrl_wr_host = host_ok && host_addr == OFF_DN0
                                 && dn_mirror;
   wire logic dn_read = mcu_rd && mcu_addr[2];

   function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
      hit = a == o;
   endfunction

   // ************************************************************
   // Mailbox bytes
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         up0 <= BYTE_RST;
         up1 <= BYTE_RST;
         up2 <= BYTE_RST;
         up3 <= BYTE_RST;
      end else if (mcu_wr_up) begin
         if (hit(mcu_addr, OFF_UP0))
            up0[MODE_HI:BIT4] <= mcu_wdata[MODE_HI:BIT4];
         if (hit(mcu_addr, OFF_UP1))
            up1 <= mcu_wdata;
         if (hit(mcu_addr, OFF_UP2))
            up2 <= mcu_wdata;
         if (hit(mcu_addr, OFF_UP3))
            up3 <= mcu_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dn0 <= BYTE_RST;
         dn1 <= BYTE_RST;
         dn2 <= BYTE_RST;
         dn3 <= BYTE_RST;
      end else if (host_ok) begin
         if (hit(host_addr, OFF_DN0))
            dn0 <= host_wdata;
         if (hit(host_addr, OFF_DN1))
            dn1 <= host_wdata;
         if (hit(host_addr, OFF_DN2))
            dn2 <= host_wdata;
         if (hit(host_addr, OFF_DN3))
            dn3 <= host_wdata;
      end
   end

   // ************************************************************
   // Mapped registers
   // ************************************************************
   // Downstream NVM data
   always_ff @(posedge clk) begin
      if (srst) begin
         nvm_data_low  <= BYTE_RST;
         nvm_data_high <= BYTE_RST;
      end else if (nvm_done && !nvm_ctrl[MODE_LO]) begin
         nvm_data_low  <= nvm_rd_low;
         nvm_data_high <= nvm_rd_high;
      end else begin
         if (mcu_wr && up_mirror && mcu_addr == OFF_UP1)
            nvm_data_low <= mcu_wdata;
         else if (host_ok && dn_mirror && host_addr == OFF_DN1)
            nvm_data_low <= host_wdata;
         if (mcu_wr && up_mirror && mcu_addr == OFF_UP2)
            nvm_data_high <= mcu_wdata;
         else if (host_ok && dn_mirror && host_addr == OFF_DN2)
            nvm_data_high <= host_wdata;
      end
   end

   wire logic [7:0] ctrl_src = ctrl_wr_mcu ? mcu_wdata : host_wdata;
   wire logic       ctrl_go  = (ctrl_wr_mcu || ctrl_wr_host)
                               && ctrl_src[START_BIT];
   always_ff @(posedge clk) begin
      if (srst) begin
         nvm_ctrl    <= BYTE_RST;
         nvm_pending <= 1'b0;
         nvm_start   <= 1'b0;
      end else begin
         nvm_start <= ctrl_go;
         if (ctrl_wr_mcu || ctrl_wr_host)
            nvm_ctrl <= {1'b0, ctrl_src[MODE_LO:0]};
         if (ctrl_go)
            nvm_pending <= 1'b1;
         else if (nvm_done)
            nvm_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst)
         mcu_ctrl <= BYTE_RST;
      else if (mcu_ctrl_wr_mcu)
         mcu_ctrl[BIT5:BIT4] <= mcu_wdata[BIT5:BIT4];
      else if (mcu_ctrl_wr_host)
         mcu_ctrl[BIT5:BIT4] <= host_wdata[BIT5:BIT4];
   end
   assign mcu_clk_sel = mcu_ctrl[BIT5:BIT4];

   // ************************************************************
   // Buttons
   // ************************************************************
   // Click latched on release
   // Cleared when the host has taken the report
   always_ff @(posedge clk) begin
      if (srst) begin
         rec_prev   <= 1'b0;
         play_prev  <= 1'b0;
         rec_click  <= 1'b0;
         play_click <= 1'b0;
      end else begin
         rec_prev  <= rec_mute_btn;
         play_prev <= play_mute_btn;
         if (rec_prev && !rec_mute_btn)
            rec_click <= 1'b1;
         else if (host_report_done)
            rec_click <= 1'b0;
         if (play_prev && !play_mute_btn)
            play_click <= 1'b1;
         else if (host_report_done)
            play_click <= 1'b0;
      end
   end

   // ************************************************************
   // Interrupt to micro
   // ************************************************************
   // Host report raises line
   // Access done raises line
   // Set wins over a clearing read in the same cycle
   always_ff @(posedge clk) begin
      if (srst)
         micro_attention_irq <= 1'b0;
      else if (host_ok || nvm_done)
         micro_attention_irq <= 1'b1;
      else if (dn_read)
         micro_attention_irq <= 1'b0;
   end

   // ************************************************************
   // Read images
   // ************************************************************
   // Upstream bytes mirrored
   wire logic [7:0] up1_img = up_mirror ? nvm_data_low  : up1;
   wire logic [7:0] up2_img = up_mirror ? nvm_data_high : up2;
   wire logic [7:0] up3_img = up_mirror ? {nvm_pending, nvm_ctrl[6:0]}
                                        : up3;
   wire logic [7:0] up0_img = {up0[MODE_HI:BIT4], rec_click, play_click,
                               vol_down_btn, vol_up_btn};
   wire logic [7:0] dn0_img = up_mirror
                              ? {MODE_ALL_ONE, mcu_ctrl[BIT5:BIT4],
                                 NIBBLE_ZERO}
                              : dn0;
   wire logic [7:0] dn1_img = up_mirror ? nvm_data_low  : dn1;
   wire logic [7:0] dn2_img = up_mirror ? nvm_data_high : dn2;
   wire logic [7:0] dn3_img = up_mirror ? {nvm_pending, nvm_ctrl[6:0]}
                                        : dn3;
   wire logic [7:0] rd_mux =
      mcu_addr == OFF_UP0 ? up0_img :
      mcu_addr == OFF_UP1 ? up1_img :
      mcu_addr == OFF_UP2 ? up2_img :
      mcu_addr == OFF_UP3 ? up3_img :
      mcu_addr == OFF_DN0 ? dn0_img :
      mcu_addr == OFF_DN1 ? dn1_img :
      mcu_addr == OFF_DN2 ? dn2_img : dn3_img;

   always_ff @(posedge clk) begin
      if (srst) begin
         mcu_rdata      <= BYTE_RST;
         host_in_report <= {4{BYTE_RST}};
      end else begin
         if (mcu_rd)
            mcu_rdata <= rd_mux;
         host_in_report <= {up3_img, up2_img, up1_img, up0_img};
      end
   end

   // ************************************************************
   // Pins and side functions
   // ************************************************************
   // GPIO level and direction
   wire logic gpio_mode = dn_mode == MODE_GPIO;
   always_ff @(posedge clk) begin
      if (srst) begin
         general_output_pins    <= '0;
         general_output_pins_oe <= '0;
         buzzer_on              <= 1'b0;
         spdif_category         <= BYTE_RST;
         spdif_category_valid   <= 1'b0;
      end else begin
         general_output_pins    <= gpio_mode ? dn1[GPIO_W-1:0] : '0;
         general_output_pins_oe <= gpio_mode ? dn2[GPIO_W-1:0] : '0;
         buzzer_on <= !up_mirror && up0[BIT5];
         spdif_category_valid <= !dn_mirror
                                 && !spdif_config[SPDIF_CAT_BIT];
         spdif_category <= dn3;
      end
   end
   // Mode field 01 and 11 need no further logic
   // Bit 7 storage or mirror, handled above
endmodule

// >>> core/mailbox_pkg.sv
// Constants for the report byte mailbox.
// Assumes a single clock domain; register offsets are byte level, field positions are bit indices.
package mailbox_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [2:0] OFF_UP0 = 3'h0;
   localparam logic [2:0] OFF_UP1 = 3'h1;
   localparam logic [2:0] OFF_UP2 = 3'h2;
   localparam logic [2:0] OFF_UP3 = 3'h3;
   localparam logic [2:0] OFF_DN0 = 3'h4;
   localparam logic [2:0] OFF_DN1 = 3'h5;
   localparam logic [2:0] OFF_DN2 = 3'h6;
   localparam logic [2:0] OFF_DN3 = 3'h7;
   // ************************************************************
   // Fields and values
   // ************************************************************
   localparam logic [7:0] BYTE_RST     = 8'h00;
   localparam logic [1:0] MODE_GPIO    = 2'h0;
   localparam logic [1:0] MODE_STORE   = 2'h1;
   localparam logic [1:0] MODE_ALL_ONE = 2'h3;
   localparam logic [3:0] NIBBLE_ZERO  = 4'h0;
   localparam int MODE_HI   = 7;
   localparam int MODE_LO   = 6;
   localparam int BIT5      = 5;
   localparam int BIT4      = 4;
   localparam int REC_BIT   = 3;
   localparam int PLAY_BIT  = 2;
   localparam int VDN_BIT   = 1;
   localparam int VUP_BIT   = 0;
   localparam int START_BIT = 7;
   localparam int SPDIF_CAT_BIT = 5;
endpackage

// >>> tb/report_byte_mailbox_properties.sv
// Concurrent checks on the report byte mailbox ports.
// Assumes a bind to the mailbox top; one clock, sync high reset.
`timescale 1ns/1ps
module report_byte_mailbox_properties
   import mailbox_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        mcu_wr,
   input wire logic        mcu_rd,
   input wire logic [2:0]  mcu_addr,
   input wire logic [7:0]  mcu_wdata,
   input wire logic [7:0]  mcu_rdata,
   input wire logic        host_wr,
   input wire logic [2:0]  host_addr,
   input wire logic [31:0] host_in_report,
   input wire logic        vol_down_btn,
   input wire logic        vol_up_btn,
   input wire logic        nvm_done,
   input wire logic        nvm_start,
   input wire logic [7:0]  nvm_ctrl,
   input wire logic [7:0]  nvm_data_low,
   input wire logic [1:0]  mcu_clk_sel,
   input wire logic        buzzer_on,
   input wire logic        micro_attention_irq
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence rd_dn0_mirrored;
      mcu_rd && !mcu_wr && mcu_addr == OFF_DN0 && host_in_report[MODE_HI];
   endsequence
   // Image lags the pins by one register stage, so wait three steady edges
   sequence btn_steady;
      $stable({vol_down_btn, vol_up_btn})[*3];
   endsequence
   a_irq_host_set: assert property (host_wr && host_addr[2]
      && !(mcu_wr && !mcu_addr[2])
      |=> micro_attention_irq) else $error("irq missed host report");
   a_irq_nvm_set: assert property (nvm_done
      |=> micro_attention_irq) else $error("irq missed nvm done");
   a_irq_rd_clear: assert property (mcu_rd && mcu_addr[2] && !host_wr
      && !nvm_done |=> !micro_attention_irq) else $error("irq not cleared");
   a_start_self_clear: assert property (nvm_start
      |=> !nvm_start && !nvm_ctrl[START_BIT]) else $error("start stuck");
   // Buzzer is registered from the stored byte, so it trails by two edges
   a_buzzer_follow: assert property (mcu_wr && mcu_addr == OFF_UP0
      && !mcu_wdata[MODE_HI] ##1 !(mcu_wr && mcu_addr == OFF_UP0)
      |=> buzzer_on == $past(mcu_wdata[BIT5], 2))
      else $error("buzzer wrong");
   a_mirror_low: assert property (mcu_wr && mcu_addr == OFF_UP1
      && host_in_report[MODE_HI] && !nvm_done
      |=> nvm_data_low == $past(mcu_wdata))
      else $error("nvm low not mirrored");
   a_dn0_mirror_read: assert property (rd_dn0_mirrored
      |=> mcu_rdata == {MODE_ALL_ONE, $past(mcu_clk_sel), NIBBLE_ZERO})
      else $error("mirrored byte 0 read wrong");
   a_vol_level: assert property (btn_steady
      |-> host_in_report[1:0] == {vol_down_btn, vol_up_btn})
      else $error("volume level wrong");
endmodule

// >>> tb/micro_model.sv
// Microcontroller model issuing register strobes to the mailbox.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
module micro_model (
   input  wire logic clk,
   input  wire logic [7:0] mcu_rdata,
   output logic      mcu_wr,
   output logic      mcu_rd,
   output logic [2:0] mcu_addr,
   output logic [7:0] mcu_wdata
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      mcu_wr = 1'h0;
      mcu_rd = 1'h0;
      mcu_addr = 3'h0;
      mcu_wdata = 8'h00;
   end
   // one strobe, may fall in step with a host write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      mcu_wr <= 1'h1;
      mcu_addr <= a;
      mcu_wdata <= d;
      @(posedge clk);
      mcu_wr <= 1'h0;
      // Released lines carry junk so stale values never look valid
      mcu_addr <= ~a;
      mcu_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      mcu_rd <= 1'h1;
      mcu_addr <= a;
      @(posedge clk);
      mcu_rd <= 1'h0;
      mcu_addr <= ~a;
      #1;
      d = mcu_rdata;
   endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the report byte mailbox.
// Assumes the micro model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("wrong value at %0t: got %h want %h", \
   $time, g, e); end end
module tb_top
   import mailbox_pkg::*;
;
   logic clk = 1'h0, srst = 1'h1, host_wr = 1'h0, host_report_done = 1'h0;
   logic nvm_done = 1'h0, rec_mute_btn = 1'h0, play_mute_btn = 1'h0;
   logic vol_down_btn = 1'h0, vol_up_btn = 1'h0;
   logic [2:0] host_addr = 3'h0;
   logic [7:0] host_wdata = 8'h00, nvm_rd_low = 8'h00;
   logic [7:0] nvm_rd_high = 8'h00, spdif_config = 8'h00, d;
   wire logic mcu_wr, mcu_rd, nvm_start, buzzer_on;
   wire logic spdif_category_valid, micro_attention_irq;
   wire logic [2:0] mcu_addr;
   wire logic [7:0] mcu_wdata, mcu_rdata, nvm_data_low, nvm_data_high;
   wire logic [7:0] nvm_ctrl, spdif_category;
   wire logic [7:0] general_output_pins, general_output_pins_oe;
   wire logic [1:0] mcu_clk_sel;
   wire logic [31:0] host_in_report;
   int mismatches = 0, total_checks = 0;
   always #25 clk = ~clk;
   micro_model u_mcu (.clk, .mcu_rdata, .mcu_wr, .mcu_rd, .mcu_addr,
      .mcu_wdata);
   report_byte_mailbox uut (.clk, .srst, .mcu_wr, .mcu_rd, .mcu_addr,
      .mcu_wdata, .mcu_rdata, .host_wr, .host_addr, .host_wdata,
      .host_report_done, .host_in_report, .rec_mute_btn, .play_mute_btn,
      .vol_down_btn, .vol_up_btn, .nvm_done, .nvm_rd_low, .nvm_rd_high,
      .nvm_start, .nvm_data_low, .nvm_data_high, .nvm_ctrl, .mcu_clk_sel,
      .spdif_config, .general_output_pins, .general_output_pins_oe,
      .buzzer_on, .spdif_category, .spdif_category_valid,
      .micro_attention_irq);
   // ****************************************
   // Drivers and scenarios
   // ****************************************
   task automatic hw(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      host_wr <= 1'h1;
      host_addr <= a;
      host_wdata <= v;
      @(posedge clk);
      host_wr <= 1'h0;
      host_wdata <= ~v;
      #1;
   endtask
   // One-cycle pulse on a strobe: 0 done, 1 rec, 2 report taken, 3 play
   task automatic pulse(input int sel, input int wait_n);
      @(posedge clk);
      case (sel)
         0: nvm_done <= 1'h1;
         1: rec_mute_btn <= 1'h1;
         2: host_report_done <= 1'h1;
         default: play_mute_btn <= 1'h1;
      endcase
      @(posedge clk);
      nvm_done <= 1'h0;
      rec_mute_btn <= 1'h0;
      host_report_done <= 1'h0;
      play_mute_btn <= 1'h0;
      repeat (wait_n) @(posedge clk);
      #1;
   endtask
   // Registered outputs settle one edge after the byte they follow
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic t_gpio;
      hw(OFF_DN0, 8'h00);
      hw(OFF_DN2, 8'h0F);
      hw(OFF_DN1, 8'h05);
      hw(OFF_DN3, 8'h33);
      tick;
      `CHK(general_output_pins_oe, 8'h0F)
      `CHK(general_output_pins, 8'h05)
      `CHK(spdif_category, 8'h33)
      `CHK(spdif_category_valid, 1'h1)
      `CHK(micro_attention_irq, 1'h1)
      @(posedge clk);
      spdif_config <= 8'h20;
      tick;
      `CHK(spdif_category_valid, 1'h0)
      @(posedge clk);
      spdif_config <= 8'h00;
      u_mcu.rd(OFF_DN1, d);
      `CHK(d, 8'h05)
      `CHK(micro_attention_irq, 1'h0)
      hw(OFF_DN0, 8'h40);
      tick;
      `CHK(general_output_pins_oe, 8'h00)
      `CHK(general_output_pins, 8'h00)
      u_mcu.rd(OFF_DN2, d);
      `CHK(d, 8'h0F)
   endtask
   task automatic t_mirror;
      hw(OFF_DN0, 8'h80);
      hw(OFF_DN1, 8'hA5);
      `CHK(nvm_data_low, 8'hA5)
      hw(OFF_DN2, 8'h5A);
      `CHK(nvm_data_high, 8'h5A)
      hw(OFF_DN3, 8'hC5);
      `CHK({nvm_start, nvm_ctrl}, 9'h145)
      u_mcu.rd(OFF_DN3, d);
      `CHK(d, 8'hC5)
      pulse(0, 0);
      `CHK(micro_attention_irq, 1'h1)
      // Read access: result is latched from the storage engine
      hw(OFF_DN3, 8'h85);
      @(posedge clk);
      nvm_rd_low <= 8'h3C;
      nvm_rd_high <= 8'hC3;
      pulse(0, 0);
      `CHK({nvm_data_high, nvm_data_low}, 16'hC33C)
      u_mcu.rd(OFF_DN1, d);
      `CHK(micro_attention_irq, 1'h0)
      hw(OFF_DN0, 8'h00);
   endtask
   task automatic t_up;
      u_mcu.wr(OFF_UP0, 8'h3F);
      tick;
      `CHK({buzzer_on, host_in_report[7:0]}, 9'h130)
      u_mcu.wr(OFF_UP1, 8'h5A);
      tick;
      `CHK(host_in_report[15:8], 8'h5A)
      // Mirroring applies to writes made once the mode is in force
      u_mcu.wr(OFF_UP0, 8'h90);
      u_mcu.wr(OFF_UP0, 8'h90);
      `CHK(mcu_clk_sel, 2'h1)
      hw(OFF_DN0, 8'h80);
      fork
         u_mcu.wr(OFF_UP3, 8'h12);
         hw(OFF_DN3, 8'h3F);
      join
      `CHK(nvm_ctrl, 8'h12)
      u_mcu.rd(OFF_DN0, d);
      `CHK(d, 8'hD0)
      u_mcu.wr(OFF_UP0, 8'h40);
      tick;
      `CHK({buzzer_on, host_in_report[7:0]}, 9'h040)
   endtask
   task automatic t_buttons;
      @(posedge clk);
      vol_down_btn <= 1'h1;
      pulse(1, 4);
      `CHK(host_in_report[3:0], 4'hA)
      pulse(3, 4);
      `CHK(host_in_report[3:0], 4'hE)
      pulse(2, 3);
      `CHK(host_in_report[3:0], 4'h2)
      @(posedge clk);
      vol_down_btn <= 1'h0;
      vol_up_btn <= 1'h1;
      tick;
      `CHK(host_in_report[1:0], 2'h1)
      @(posedge clk);
      vol_up_btn <= 1'h0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         u_mcu.rd(3'(i), d);
         `CHK(d, 8'h00)
      end
      t_gpio;
      t_mirror;
      t_up;
      t_buttons;
      wrap_up;
   end
   initial begin
      #200us;
      mismatches++;
      wrap_up;
   end
endmodule
bind report_byte_mailbox report_byte_mailbox_properties u_props (.clk,
   .srst, .mcu_wr, .mcu_rd, .mcu_addr, .mcu_wdata, .mcu_rdata, .host_wr,
   .host_addr, .host_in_report, .vol_down_btn, .vol_up_btn, .nvm_done,
   .nvm_start, .nvm_ctrl, .nvm_data_low, .mcu_clk_sel, .buzzer_on,
   .micro_attention_irq);
